// *** verilog/lbs_pkg.sv ***
// Purpose: Shared constants and types for the display power sequencer
// Assumes: 40 MHz clock
// Notes:   Delays in milliseconds are scaled to cycles in the sequencer
package lbs_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int LBS_CLOCK_HZ = 40000000;
	localparam int LBS_BIAS_SETTLE_US = 200;
	localparam int LBS_OTP_LOAD_US = 700;
	localparam int LBS_MS_PER_S = 1000;
	localparam int LBS_US_PER_S = 1000000;
	localparam int LBS_BIAS_SETTLE_CYC =
		LBS_BIAS_SETTLE_US * (LBS_CLOCK_HZ / LBS_US_PER_S);
	localparam int LBS_OTP_LOAD_CYC =
		LBS_OTP_LOAD_US * (LBS_CLOCK_HZ / LBS_US_PER_S);
	localparam int LBS_CYC_PER_MS = LBS_CLOCK_HZ / LBS_MS_PER_S;
	localparam logic [7:0] LBS_MAX_DELAY_MS = 8'hC8;
	localparam int LBS_TIMER_W = 24;
	localparam int LBS_BRIGHT_W = 11;
	localparam logic [LBS_BRIGHT_W-1:0] LBS_BRIGHT_ZERO = 11'h000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		LBS_OFF       = 5'h00,
		LBS_BIAS_WAIT = 5'h01,
		LBS_OTP_LOAD  = 5'h03,
		LBS_STANDBY   = 5'h02,
		LBS_CTRL_UP   = 5'h06,
		LBS_BOOST_UP  = 5'h07,
		LBS_VPOS_UP   = 5'h05,
		LBS_VNEG_UP   = 5'h04,
		LBS_OREF_UP   = 5'h0C,
		LBS_ACTIVE    = 5'h0D,
		LBS_BL_ON     = 5'h0F,
		LBS_BL_DOWN   = 5'h0E,
		LBS_VPOS_DN   = 5'h0A,
		LBS_VNEG_DN   = 5'h0B,
		LBS_OREF_DN   = 5'h09,
		LBS_BOOST_DN  = 5'h08,
		LBS_CTRL_DN   = 5'h18
	} lbs_state_t;

	typedef struct packed {
		logic undervoltage;
		logic over_temperature;
		logic backlight_short;
		logic backlight_overcurrent;
		logic reference_overcurrent;
		logic positive_overcurrent;
		logic pump_short;
	} lbs_faults_t;

	typedef struct packed {
		logic control_regulator;
		logic boost;
		logic positive_bias_regulator;
		logic negative_charge_pump;
		logic reference_regulator;
		logic backlight;
	} lbs_rails_t;

	typedef struct packed {
		logic [7:0] control_ms;
		logic [7:0] positive_up_ms;
		logic [7:0] negative_up_ms;
		logic [7:0] reference_up_ms;
		logic [7:0] positive_down_ms;
		logic [7:0] negative_down_ms;
		logic [7:0] reference_down_ms;
	} lbs_delays_t;

	localparam lbs_rails_t LBS_RAILS_OFF = '0;

endpackage : lbs_pkg

// *** verilog/lbs_sync.sv ***
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clock
// Notes:   First stage is read only by the second
`timescale 1ns/100ps
module lbs_sync import lbs_pkg::*; #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] synced
);

	logic [WIDTH-1:0] stage;

	// ----------------------------------------------------------------
	// Two stages
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rstn) begin
			stage <= '0;
			synced <= '0;
		end else begin
			stage <= pin;
			synced <= stage;
		end
	end

endmodule : lbs_sync

// *** verilog/lbs_timer.sv ***
// Purpose: Down counter for sequencer step delays
// Assumes: start is a one-cycle pulse
// Notes:   done is high while no count is running
`timescale 1ns/100ps
module lbs_timer import lbs_pkg::*; (
	input wire logic clock,
	input wire logic rstn,
	input wire logic start,
	input wire logic [LBS_TIMER_W-1:0] load,
	output logic done
);

	logic [LBS_TIMER_W-1:0] count;

	// ----------------------------------------------------------------
	// Count
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rstn) begin
			count <= '0;
		end else if (start) begin
			count <= load;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			done <= 1'b1;
		end else if (start) begin
			done <= 1'b0;
		end else begin
			done <= (count <= {{(LBS_TIMER_W-1){1'b0}}, 1'b1});
		end
	end

endmodule : lbs_timer

// *** verilog/lbs_sequencer.sv ***
// Purpose: Power-state sequencer for display bias and backlight supplies
// Assumes: Pins pass two flops; configuration comes from same clock
// Notes:   Delay settings are in milliseconds, clamped to the maximum
//
// What this block does
// - Leave reset for Standby once reset pin high and supply above UVLO.
// - Enable references and bias, then wait the bias settling delay.
// - Load registers from one-time memory before Standby.
// - Standby: writes allowed, bias on, oscillator and supplies off.
// - Run oscillator while a register write is in progress in Standby.
// - Display enable high, by pin or bit, starts power-up.
// - Start control regulator, boost, then bias; skip disabled regulator.
// - Wait programmed 0 to 200 ms after control regulator enable.
// - Hold boost step until boost output reaches 90 percent.
// - Enable positive, negative, reference outputs in turn by delays.
// - Start backlight only with enable bit set and brightness nonzero.
// - Backlight bit or brightness zero turns backlight off, supplies stay.
// - Display enable low shuts backlight off first.
// - Then disable positive, negative, reference outputs by shutdown delays.
// - Boost off, then after the control delay Standby, with control regulator off on entry.
// - Any listed fault runs the shutdown sequence.
`timescale 1ns/100ps
module lbs_sequencer import lbs_pkg::*; #(
	parameter int BIAS_SETTLE_CYC = LBS_BIAS_SETTLE_CYC,
	parameter int OTP_LOAD_CYC = LBS_OTP_LOAD_CYC,
	parameter int CYC_PER_MS = LBS_CYC_PER_MS
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic reset_n,
	input wire logic supply_above_uvlo,
	input wire logic display_power_enable,
	input wire logic display_power_enable_bit,
	input wire logic write_in_progress,
	input wire logic otp_load_done,
	input wire logic control_regulator_enable,
	input wire lbs_delays_t delays,
	input wire logic backlight_enable_bit,
	input wire logic [LBS_BRIGHT_W-1:0] brightness,
	input wire logic boost_at_ninety,
	input wire logic backlight_idle,
	input wire lbs_faults_t fault_pins,
	output logic references_on,
	output logic oscillator_on,
	output logic otp_loading,
	output logic standby,
	output lbs_rails_t rails,
	output lbs_state_t state
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	localparam int PIN_W = 4 + $bits(lbs_faults_t);

	logic [PIN_W-1:0] pins_raw;
	logic [PIN_W-1:0] pins;
	logic reset_pin;
	logic uvlo_ok;
	logic enable_pin;
	logic boost_good;
	lbs_faults_t faults;

	assign pins_raw = {reset_n, supply_above_uvlo, display_power_enable,
		boost_at_ninety, fault_pins};

	lbs_sync #(.WIDTH(PIN_W)) u_sync (
		.clock(clock),
		.rstn(rstn),
		.pin(pins_raw),
		.synced(pins)
	);

	assign reset_pin = pins[PIN_W-1];
	assign uvlo_ok = pins[PIN_W-2];
	assign enable_pin = pins[PIN_W-3];
	assign boost_good = pins[PIN_W-4];
	assign faults = pins[$bits(lbs_faults_t)-1:0];

	// ----------------------------------------------------------------
	// Conditions
	// ----------------------------------------------------------------
	logic powered;
	logic enabled;
	logic fault_any;
	logic shut_request;
	logic backlight_ok;
	logic timer_start;
	logic timer_done;
	logic [LBS_TIMER_W-1:0] timer_load;
	lbs_state_t next_state;
	lbs_rails_t next_rails;

	assign powered = reset_pin && uvlo_ok;
	assign enabled = enable_pin || display_power_enable_bit;
	assign fault_any = (|faults) || !uvlo_ok;
	assign shut_request = !enabled || fault_any;
	assign backlight_ok = backlight_enable_bit &&
		(brightness != LBS_BRIGHT_ZERO);

	// ----------------------------------------------------------------
	// Delay scaling
	// ----------------------------------------------------------------
	function automatic logic [LBS_TIMER_W-1:0] ms_cycles(
		input logic [7:0] ms
	);
		logic [7:0] clamped;
		logic [LBS_TIMER_W-1:0] scale;
		clamped = (ms > LBS_MAX_DELAY_MS) ? LBS_MAX_DELAY_MS : ms;
		scale = LBS_TIMER_W'(CYC_PER_MS);
		ms_cycles = LBS_TIMER_W'(clamped * scale);
	endfunction : ms_cycles

	function automatic logic [LBS_TIMER_W-1:0] step_delay(
		input lbs_state_t s,
		input lbs_delays_t d
	);
		case (s)
			LBS_BIAS_WAIT: step_delay = LBS_TIMER_W'(BIAS_SETTLE_CYC);
			LBS_OTP_LOAD: step_delay = LBS_TIMER_W'(OTP_LOAD_CYC);
			LBS_CTRL_UP: step_delay = ms_cycles(d.control_ms);
			LBS_VPOS_UP: step_delay = ms_cycles(d.positive_up_ms);
			LBS_VNEG_UP: step_delay = ms_cycles(d.negative_up_ms);
			LBS_OREF_UP: step_delay = ms_cycles(d.reference_up_ms);
			LBS_VPOS_DN: step_delay = ms_cycles(d.positive_down_ms);
			LBS_VNEG_DN: step_delay = ms_cycles(d.negative_down_ms);
			LBS_OREF_DN: step_delay = ms_cycles(d.reference_down_ms);
			LBS_CTRL_DN: step_delay = ms_cycles(d.control_ms);
			default: step_delay = '0;
		endcase
	endfunction : step_delay

	assign timer_start = (next_state != state);
	assign timer_load = step_delay(next_state, delays);

	lbs_timer u_timer (
		.clock(clock),
		.rstn(rstn),
		.start(timer_start),
		.load(timer_load),
		.done(timer_done)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			LBS_OFF: begin
				if (powered) begin
					next_state = LBS_BIAS_WAIT;
				end
			end
			LBS_BIAS_WAIT: begin
				if (timer_done) begin
					next_state = LBS_OTP_LOAD;
				end
			end
			LBS_OTP_LOAD: begin
				if (timer_done && otp_load_done) begin
					next_state = LBS_STANDBY;
				end
			end
			LBS_STANDBY: begin
				if (enabled && !fault_any) begin
					next_state = control_regulator_enable ?
						LBS_CTRL_UP : LBS_BOOST_UP;
				end
			end
			LBS_CTRL_UP: begin
				if (shut_request) begin
					next_state = LBS_VPOS_DN;
				end else if (timer_done) begin
					next_state = LBS_BOOST_UP;
				end
			end
			LBS_BOOST_UP: begin
				if (shut_request) begin
					next_state = LBS_VPOS_DN;
				end else if (boost_good) begin
					next_state = LBS_VPOS_UP;
				end
			end
			LBS_VPOS_UP: begin
				if (shut_request) begin
					next_state = LBS_VPOS_DN;
				end else if (timer_done) begin
					next_state = LBS_VNEG_UP;
				end
			end
			LBS_VNEG_UP: begin
				if (shut_request) begin
					next_state = LBS_VPOS_DN;
				end else if (timer_done) begin
					next_state = LBS_OREF_UP;
				end
			end
			LBS_OREF_UP: begin
				if (shut_request) begin
					next_state = LBS_VPOS_DN;
				end else if (timer_done) begin
					next_state = LBS_ACTIVE;
				end
			end
			LBS_ACTIVE: begin
				if (shut_request) begin
					next_state = LBS_VPOS_DN;
				end else if (backlight_ok) begin
					next_state = LBS_BL_ON;
				end
			end
			LBS_BL_ON: begin
				if (shut_request) begin
					next_state = LBS_BL_DOWN;
				end else if (!backlight_ok) begin
					next_state = LBS_ACTIVE;
				end
			end
			LBS_BL_DOWN: begin
				if (backlight_idle) begin
					next_state = LBS_VPOS_DN;
				end
			end
			LBS_VPOS_DN: begin
				if (timer_done) begin
					next_state = LBS_VNEG_DN;
				end
			end
			LBS_VNEG_DN: begin
				if (timer_done) begin
					next_state = LBS_OREF_DN;
				end
			end
			LBS_OREF_DN: begin
				if (timer_done) begin
					next_state = LBS_BOOST_DN;
				end
			end
			LBS_BOOST_DN: begin
				next_state = rails.control_regulator ?
					LBS_CTRL_DN : LBS_STANDBY;
			end
			LBS_CTRL_DN: begin
				if (timer_done) begin
					next_state = LBS_STANDBY;
				end
			end
			default: begin
				next_state = LBS_OFF;
			end
		endcase
		if (!reset_pin) begin
			next_state = LBS_OFF;
		end else if (!uvlo_ok && state == LBS_STANDBY) begin
			next_state = LBS_OFF;
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			state <= LBS_OFF;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// Rail enables
	// ----------------------------------------------------------------
	always_comb begin
		next_rails = rails;
		case (next_state)
			LBS_OFF, LBS_BIAS_WAIT, LBS_OTP_LOAD, LBS_STANDBY: begin
				next_rails = LBS_RAILS_OFF;
			end
			LBS_CTRL_UP: begin
				next_rails.control_regulator = 1'b1;
			end
			LBS_BOOST_UP: begin
				next_rails.boost = 1'b1;
			end
			LBS_VPOS_UP: begin
				next_rails.positive_bias_regulator = 1'b1;
			end
			LBS_VNEG_UP: begin
				next_rails.negative_charge_pump = 1'b1;
			end
			LBS_OREF_UP: begin
				next_rails.reference_regulator = 1'b1;
			end
			LBS_ACTIVE: begin
				next_rails.backlight = 1'b0;
			end
			LBS_BL_ON: begin
				next_rails.backlight = 1'b1;
			end
			LBS_BL_DOWN: begin
				next_rails.backlight = 1'b0;
			end
			LBS_VPOS_DN: begin
				next_rails.backlight = 1'b0;
				next_rails.positive_bias_regulator = 1'b0;
			end
			LBS_VNEG_DN: begin
				next_rails.negative_charge_pump = 1'b0;
			end
			LBS_OREF_DN: begin
				next_rails.reference_regulator = 1'b0;
			end
			LBS_BOOST_DN, LBS_CTRL_DN: begin
				next_rails.boost = 1'b0;
			end
			default: begin
				next_rails = LBS_RAILS_OFF;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			rails <= LBS_RAILS_OFF;
		end else begin
			rails <= next_rails;
		end
	end

	// ----------------------------------------------------------------
	// Housekeeping outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!rstn) begin
			references_on <= 1'b0;
			otp_loading <= 1'b0;
			standby <= 1'b0;
		end else begin
			references_on <= (next_state != LBS_OFF);
			otp_loading <= (next_state == LBS_OTP_LOAD);
			standby <= (next_state == LBS_STANDBY);
		end
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			oscillator_on <= 1'b0;
		end else begin
			case (next_state)
				LBS_OFF, LBS_BIAS_WAIT, LBS_OTP_LOAD: begin
					oscillator_on <= 1'b0;
				end
				LBS_STANDBY: begin
					oscillator_on <= write_in_progress;
				end
				default: begin
					oscillator_on <= 1'b1;
				end
			endcase
		end
	end

endmodule : lbs_sequencer

// *** bench/lbs_sequencer_checker.sv ***
// Purpose: Port assertions for the display power sequencer
// Assumes: Bound to lbs_sequencer, pins lag two flops
// Notes:   Order checks pause while the reset pin is low
`timescale 1ns/100ps
module lbs_sequencer_checker import lbs_pkg::*; (
	input wire logic clock,
	input wire logic rstn,
	input wire logic reset_n,
	input wire logic write_in_progress,
	input wire logic backlight_enable_bit,
	input wire logic [LBS_BRIGHT_W-1:0] brightness,
	input wire logic boost_at_ninety,
	input wire logic references_on,
	input wire logic oscillator_on,
	input wire logic standby,
	input wire lbs_rails_t rails,
	input wire lbs_state_t state
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn || !reset_n);
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_pin_reset;
		@(posedge clock) disable iff (!rstn)
		!reset_n [*3] |=> state == LBS_OFF && rails == LBS_RAILS_OFF;
	endproperty
	a_pin_reset: assert property (p_pin_reset)
		else $error("reset pin did not stop the sequencer");
	property p_standby_quiet;
		state == LBS_STANDBY |->
			standby && references_on && rails == LBS_RAILS_OFF;
	endproperty
	a_standby_quiet: assert property (p_standby_quiet)
		else $error("standby outputs wrong");
	property p_write_osc;
		state == LBS_STANDBY && $past(state) == LBS_STANDBY |->
			oscillator_on == $past(write_in_progress);
	endproperty
	a_write_osc: assert property (p_write_osc)
		else $error("oscillator does not follow write in standby");
	property p_boost_first;
		$rose(rails.boost) |->
			state == LBS_BOOST_UP && !rails.positive_bias_regulator;
	endproperty
	a_boost_first: assert property (p_boost_first)
		else $error("boost started out of order");
	property p_boost_good;
		state == LBS_VPOS_UP && $past(state) == LBS_BOOST_UP |->
			$past(boost_at_ninety, 2);
	endproperty
	a_boost_good: assert property (p_boost_good)
		else $error("bias started before boost good");
	property p_bl_start;
		$rose(rails.backlight) |-> $past(backlight_enable_bit) &&
			$past(brightness) != LBS_BRIGHT_ZERO;
	endproperty
	a_bl_start: assert property (p_bl_start)
		else $error("backlight started without enable and brightness");
	property p_bl_drop;
		state == LBS_BL_ON && (!backlight_enable_bit ||
			brightness == LBS_BRIGHT_ZERO) |=>
			!rails.backlight && rails.reference_regulator;
	endproperty
	a_bl_drop: assert property (p_bl_drop)
		else $error("backlight drop handled wrongly");
	property p_bias_down;
		$fell(rails.positive_bias_regulator) |-> !rails.backlight &&
			state == LBS_VPOS_DN && !$past(rails.backlight) &&
			$stable(rails.negative_charge_pump) &&
			$stable(rails.reference_regulator);
	endproperty
	a_bias_down: assert property (p_bias_down)
		else $error("positive bias went off out of order");
	property p_ctrl_last;
		$fell(rails.control_regulator) |->
			state == LBS_STANDBY && rails == LBS_RAILS_OFF;
	endproperty
	a_ctrl_last: assert property (p_ctrl_last)
		else $error("control regulator went off out of order");
endmodule : lbs_sequencer_checker

bind lbs_sequencer lbs_sequencer_checker chk (.clock(clock),
	.rstn(rstn), .reset_n(reset_n),
	.write_in_progress(write_in_progress),
	.backlight_enable_bit(backlight_enable_bit),
	.brightness(brightness), .boost_at_ninety(boost_at_ninety),
	.references_on(references_on), .oscillator_on(oscillator_on),
	.standby(standby), .rails(rails), .state(state));

// *** bench/lbs_plant_model.sv ***
// Purpose: Supply plant answering the sequencer rails
// Assumes: slow selects long ramps
// Notes:   Levels only, no analog detail
`timescale 1ns/100ps
module lbs_plant_model import lbs_pkg::*; (
	input wire logic clock,
	input wire logic slow,
	input wire lbs_rails_t rails,
	output logic boost_at_ninety,
	output logic backlight_idle
);
	logic [4:0] ramp = 5'h00;
	logic [4:0] fade = 5'h00;
	always_ff @(posedge clock) begin
		ramp <= !rails.boost ? 5'h00 : ramp + 5'(ramp != 5'h1F);
		fade <= rails.backlight ? 5'h00 : fade + 5'(fade != 5'h1F);
	end
	// Boost good only after its ramp
	assign boost_at_ninety = rails.boost &&
		ramp >= (slow ? 5'h0C : 5'h02);
	// Backlight ramp-down takes time
	assign backlight_idle = !rails.backlight &&
		fade >= (slow ? 5'h08 : 5'h01);
endmodule : lbs_plant_model

// *** bench/test_lcd_bias_backlight_power_sequencer.sv ***
// Purpose: Sequence tests for the display power sequencer
// Assumes: Inputs change at falling edges
// Notes:   Short delay parameters keep the run brief
`timescale 1ns/100ps
module test_lcd_bias_backlight_power_sequencer import lbs_pkg::*;;
	logic clock = 1'b0, rstn, reset_n, supply_above_uvlo, slow;
	logic display_power_enable, display_power_enable_bit;
	logic write_in_progress, otp_load_done, control_regulator_enable;
	logic backlight_enable_bit, boost_at_ninety, backlight_idle;
	logic references_on, oscillator_on, otp_loading, standby;
	logic [LBS_BRIGHT_W-1:0] brightness;
	lbs_delays_t delays;
	lbs_faults_t fault_pins;
	lbs_rails_t rails;
	lbs_state_t state;
	int bad_count = 0, total_checks = 0, n;
	lbs_state_t down_order [7] = '{LBS_BL_DOWN, LBS_VPOS_DN,
		LBS_VNEG_DN, LBS_OREF_DN, LBS_BOOST_DN, LBS_CTRL_DN, LBS_STANDBY};
	always #12.5 clock = ~clock;
	lbs_sequencer #(.BIAS_SETTLE_CYC(20), .OTP_LOAD_CYC(30),
		.CYC_PER_MS(10)) dut (.clock(clock), .rstn(rstn),
		.reset_n(reset_n), .supply_above_uvlo(supply_above_uvlo),
		.display_power_enable(display_power_enable),
		.display_power_enable_bit(display_power_enable_bit),
		.write_in_progress(write_in_progress),
		.otp_load_done(otp_load_done),
		.control_regulator_enable(control_regulator_enable),
		.delays(delays), .backlight_enable_bit(backlight_enable_bit),
		.brightness(brightness), .boost_at_ninety(boost_at_ninety),
		.backlight_idle(backlight_idle), .fault_pins(fault_pins),
		.references_on(references_on), .oscillator_on(oscillator_on),
		.otp_loading(otp_loading), .standby(standby), .rails(rails),
		.state(state));
	lbs_plant_model plant (.clock(clock), .slow(slow), .rails(rails),
		.boost_at_ninety(boost_at_ninety),
		.backlight_idle(backlight_idle));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic wait_state(input lbs_state_t s, input int lim);
		n = 0;
		while (state !== s && n < lim) begin
			@(negedge clock);
			n++;
		end
		check("state", 16'(s), 16'(state));
	endtask : wait_state
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		#125000;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		{rstn, display_power_enable, display_power_enable_bit} = 3'h0;
		{write_in_progress, otp_load_done, backlight_enable_bit} = 3'h0;
		{reset_n, supply_above_uvlo, control_regulator_enable} = 3'h7;
		slow = 1'b1;
		brightness = 11'h000;
		fault_pins = '0;
		delays = {8'h03, 8'h01, 8'h02, 8'h01, 8'h01, 8'h01, 8'h01};
		repeat (10) @(negedge clock);
		rstn = 1'b1;
		wait_state(LBS_BIAS_WAIT, 6);
		check("references", 1, references_on);
		wait_state(LBS_OTP_LOAD, 40);
		check("settle", 1, n >= 19);
		repeat (60) @(negedge clock);
		check("loading", 16'(LBS_OTP_LOAD), 16'(state));
		check("otp_loading", 1, otp_loading);
		otp_load_done = 1'b1;
		wait_state(LBS_STANDBY, 5);
		check("standby", 1, standby);
		check("rails", 0, rails);
		check("osc", 0, oscillator_on);
		write_in_progress = 1'b1;
		repeat (2) @(negedge clock);
		check("osc", 1, oscillator_on);
		write_in_progress = 1'b0;
		repeat (2) @(negedge clock);
		check("osc", 0, oscillator_on);
		display_power_enable = 1'b1;
		wait_state(LBS_CTRL_UP, 5);
		check("ctrl", 1, rails.control_regulator);
		wait_state(LBS_BOOST_UP, 40);
		check("ctrl delay", 1, n >= 29 && n <= 33);
		wait_state(LBS_VPOS_UP, 30);
		check("boost wait", 1, n >= 12);
		wait_state(LBS_VNEG_UP, 20);
		wait_state(LBS_OREF_UP, 30);
		wait_state(LBS_ACTIVE, 20);
		check("rails up", 16'h003E, rails);
		brightness = 11'h400;
		repeat (4) @(negedge clock);
		check("no bl", 16'(LBS_ACTIVE), 16'(state));
		backlight_enable_bit = 1'b1;
		wait_state(LBS_BL_ON, 3);
		check("bl", 1, rails.backlight);
		brightness = 11'h000;
		wait_state(LBS_ACTIVE, 3);
		check("bias kept", 1, rails.reference_regulator);
		brightness = 11'h7FF;
		wait_state(LBS_BL_ON, 3);
		display_power_enable = 1'b0;
		foreach (down_order[i])
			wait_state(down_order[i], 60);
		check("all off", 0, rails);
		{control_regulator_enable, slow, backlight_enable_bit} = 3'h0;
		for (int i = 0; i < 7; i++) begin
			display_power_enable_bit = 1'b1;
			wait_state(LBS_BOOST_UP, 2);
			wait_state(LBS_ACTIVE, 60);
			check("rails up", 16'h001E, rails);
			fault_pins = lbs_faults_t'(7'h01 << i);
			wait_state(LBS_VPOS_DN, 6);
			{fault_pins, display_power_enable_bit} = '0;
			wait_state(LBS_STANDBY, 60);
		end
		supply_above_uvlo = 1'b0;
		wait_state(LBS_OFF, 6);
		supply_above_uvlo = 1'b1;
		wait_state(LBS_STANDBY, 100);
		reset_n = 1'b0;
		repeat (4) @(negedge clock);
		check("pin reset", 16'(LBS_OFF), 16'(state));
		reset_n = 1'b1;
		wait_state(LBS_STANDBY, 100);
		tally_and_finish();
	end
endmodule : test_lcd_bias_backlight_power_sequencer
